// ---- pcmi_pkg.sv ----
// Package: register map, reset values, start-up states and field positions for the init controller
package pcmi_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL        = 8'h00;
    localparam logic [7:0] OFF_STATUS      = 8'h04;
    localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h08;
    localparam logic [7:0] OFF_IDSEL_MASK  = 8'h0C;
    localparam logic [7:0] OFF_IN_LIMIT    = 8'h10;
    localparam logic [7:0] OFF_IN_XLATE    = 8'h14;
    localparam logic [7:0] OFF_P_MEM_WIN   = 8'h18;
    localparam logic [7:0] OFF_P_IO_WIN    = 8'h1C;
    localparam logic [7:0] OFF_S_MEM_WIN   = 8'h20;
    localparam logic [7:0] OFF_S_IO_WIN    = 8'h24;
    localparam logic [7:0] OFF_FUNC_INFO   = 8'h28;
    // Field positions
    localparam int CTRL_RELEASE_BIT  = 0;
    localparam int CTRL_PRIVATE_BIT  = 1;
    localparam int EBC_CFG_DIS_BIT   = 0;
    localparam int IDSEL_LO          = 16;
    localparam int IDSEL_W           = 5;
    // Reset values, function numbers and AXI response codes
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] RST_IN_LIMIT = 32'h0000_0000;
    localparam logic [31:0] BOOT_ADDR    = 32'hFEFF_FF30;
    localparam logic [1:0]  FUNC_BRIDGE  = 2'h0;
    localparam logic [1:0]  FUNC_XLATE   = 2'h1;
    localparam logic [1:0]  AXI_OKAY     = 2'h0;
    localparam logic [1:0]  AXI_SLVERR   = 2'h2;
    // Start-up sequence
    typedef enum logic [1:0] {PCMI_SAMPLE, PCMI_HOLD, PCMI_RUN} pcmi_state_t;
endpackage

// ---- pcmi_sync_if.sv ----
// Interface and two-stage synchroniser for the strap pins
`timescale 1ns/1ps
`default_nettype none
interface pcmi_strap_if;
    logic mode_s;
    logic retry_s;
    modport src (output mode_s, output retry_s);
    modport dst (input mode_s, input retry_s);
endinterface

module pcmi_sync (
    input  wire logic   aclk,        // Clock
    input  wire logic   aresetn,     // Sync reset, active low
    input  wire logic   mode_pin,    // Raw mode strap
    input  wire logic   retry_pin,   // Raw retry strap
    pcmi_strap_if.src   straps       // Synchronised straps
);
    logic [1:0] m_q, m_d, r_q, r_d;
    // Shift chains; stage 0 feeds only stage 1
    always_comb begin
        m_d = {m_q[0], mode_pin};
        r_d = {r_q[0], retry_pin};
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            m_q <= 2'h3;
            r_q <= 2'h3;
        end else begin
            m_q <= m_d;
            r_q <= r_d;
        end
    end
    assign straps.mode_s  = m_q[1];
    assign straps.retry_s = r_q[1];
endmodule
`default_nettype wire

// ---- pcmi_top.sv ----
// Start-up controller: strap modes, config retry gate, inbound translation window, AXI4-Lite regs
`timescale 1ns/1ps
`default_nettype none
module pcmi_top
    import pcmi_pkg::*;
(
    input  wire logic        aclk,            // Clock, 125 MHz
    input  wire logic        aresetn,         // Sync reset, active low
    input  wire logic        mode_strap,      // Mode strap pin
    input  wire logic        retry_strap,     // Retry strap pin
    input  wire logic        cfg_req,         // Host config access request
    input  wire logic [1:0]  cfg_func,        // Function addressed
    input  wire logic [31:0] host_addr,       // Host inbound address
    input  wire logic [31:0] sec_cfg_addr,    // Type 0 secondary address before masking
    input  wire logic        sec_fwd_req,     // Secondary master wants primary side
    input  wire logic [31:0] s_axi_awaddr,    // AXI write address
    input  wire logic        s_axi_awvalid,   // AXI write address valid
    output logic             s_axi_awready,   // AXI write address ready
    input  wire logic [31:0] s_axi_wdata,     // AXI write data
    input  wire logic [3:0]  s_axi_wstrb,     // AXI byte strobes
    input  wire logic        s_axi_wvalid,    // AXI write data valid
    output logic             s_axi_wready,    // AXI write data ready
    output logic [1:0]       s_axi_bresp,     // AXI write response
    output logic             s_axi_bvalid,    // AXI write response valid
    input  wire logic        s_axi_bready,    // AXI write response ready
    input  wire logic [31:0] s_axi_araddr,    // AXI read address
    input  wire logic        s_axi_arvalid,   // AXI read address valid
    output logic             s_axi_arready,   // AXI read address ready
    output logic [31:0]      s_axi_rdata,     // AXI read data
    output logic [1:0]       s_axi_rresp,     // AXI read response
    output logic             s_axi_rvalid,    // AXI read valid
    input  wire logic        s_axi_rready,    // AXI read ready
    output logic             core_reset_n,    // Embedded core reset, active low
    output logic [31:0]      boot_fetch_addr, // First fetch address of core
    output logic             cfg_retry,       // Config access ends in retry
    output logic             cfg_accept,      // Config access accepted
    output logic             cfg_func_bridge, // Access hits function 0
    output logic             cfg_func_xlate,  // Access hits function 1
    output logic             in_hit,          // Host address inside inbound window
    output logic [31:0]      local_addr,      // Translated local address
    output logic [31:0]      sec_addr_out,    // Secondary address after masking
    output logic [31:0]      sec_addr_oe,     // Per-bit drive enable
    output logic             sec_fwd_grant,   // Forwarding allowed
    output logic [1:0]       init_mode        // Decoded mode
);
    pcmi_strap_if straps ();
    pcmi_sync u_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .mode_pin  (mode_strap),
        .retry_pin (retry_strap),
        .straps    (straps)
    );

    pcmi_state_t st_q, st_d;
    logic [1:0]  mode_q, mode_d;
    logic [2:0]  wait_q, wait_d;
    logic        rel_q, rel_d, rel_prev_q;
    logic        ccd_q, ccd_d, priv_q, priv_d;
    logic [31:0] mask_q, mask_d, lim_q, lim_d, xl_q, xl_d;
    logic [31:0] pmw_q, pmw_d, piw_q, piw_d, smw_q, smw_d, siw_q, siw_d;

    // Wait for both synchroniser stages to fill before catching the straps
    always_comb begin
        st_d   = st_q;
        mode_d = mode_q;
        wait_d = wait_q;
        case (st_q)
            PCMI_SAMPLE: begin
                wait_d = wait_q + 3'h1;
                if (wait_q == 3'h3) begin
                    mode_d = {straps.mode_s, straps.retry_s};
                    st_d   = PCMI_HOLD;
                end
            end
            PCMI_HOLD: begin
                // Modes 0 and 1 never leave hold; only modes 2 and 3 release
                if (mode_q[1] && rel_q)
                    st_d = PCMI_RUN;
            end
            PCMI_RUN: st_d = PCMI_RUN;
            default:  st_d = PCMI_SAMPLE;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q   <= PCMI_SAMPLE;
            mode_q <= 2'h3;
            wait_q <= 3'h0;
        end else begin
            st_q   <= st_d;
            mode_q <= mode_d;
            wait_q <= wait_d;
        end
    end

    // AXI4-Lite slave: address and data taken independently, response after both
    logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bv_q, bv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d;
    logic        rv_q, rv_d;
    logic [31:0] rd_q, rd_d;
    logic [1:0]  rr_q, rr_d;
    logic        do_wr;
    logic [31:0] wmask;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        awa_d     = awa_q;
        wd_d      = wd_q;
        ws_d      = ws_q;
        bv_d      = bv_q;
        br_d      = br_q;
        if (s_axi_awvalid && !aw_hold_q && !bv_q) begin
            aw_hold_d = 1'b1;
            awa_d     = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !w_hold_q && !bv_q) begin
            w_hold_d = 1'b1;
            wd_d     = s_axi_wdata;
            ws_d     = s_axi_wstrb;
        end
        do_wr = aw_hold_q && w_hold_q && !bv_q;
        if (do_wr) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bv_d      = 1'b1;
            br_d      = (awa_q <= OFF_S_IO_WIN && awa_q[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR;
        end else if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
    end

    // Register writes; core writes the same map as software
    always_comb begin
        rel_d  = rel_q;
        priv_d = priv_q;
        ccd_d  = ccd_q;
        mask_d = mask_q;
        lim_d  = lim_q;
        xl_d   = xl_q;
        pmw_d  = pmw_q;
        piw_d  = piw_q;
        smw_d  = smw_q;
        siw_d  = siw_q;
        if (do_wr) begin
            case (awa_q)
                OFF_CTRL: begin
                    if (ws_q[0]) begin
                        rel_d  = wd_q[CTRL_RELEASE_BIT];
                        priv_d = wd_q[CTRL_PRIVATE_BIT];
                    end
                end
                OFF_BRIDGE_CTRL: begin
                    if (ws_q[0] && !wd_q[EBC_CFG_DIS_BIT])
                        ccd_d = 1'b0;
                end
                OFF_IDSEL_MASK: mask_d = merge(mask_q, wd_q, wmask);
                OFF_IN_LIMIT:   lim_d  = merge(lim_q, wd_q, wmask);
                OFF_IN_XLATE:   xl_d   = merge(xl_q, wd_q, wmask);
                OFF_P_MEM_WIN:  pmw_d  = merge(pmw_q, wd_q, wmask);
                OFF_P_IO_WIN:   piw_d  = merge(piw_q, wd_q, wmask);
                OFF_S_MEM_WIN:  smw_d  = merge(smw_q, wd_q, wmask);
                OFF_S_IO_WIN:   siw_d  = merge(siw_q, wd_q, wmask);
                default: ;
            endcase
        end
        // Setting the disable bit wins over a clear in the same cycle
        if (mode_q == 2'h3 && rel_q && !rel_prev_q)
            ccd_d = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q  <= 1'b0;
            w_hold_q   <= 1'b0;
            awa_q      <= 8'h00;
            wd_q       <= RST_ZERO;
            ws_q       <= 4'h0;
            bv_q       <= 1'b0;
            br_q       <= AXI_OKAY;
            rel_q      <= 1'b0;
            rel_prev_q <= 1'b0;
            priv_q     <= 1'b0;
            ccd_q      <= 1'b0;
            mask_q     <= RST_ZERO;
            lim_q      <= RST_IN_LIMIT;
            xl_q       <= RST_ZERO;
            pmw_q      <= RST_ZERO;
            piw_q      <= RST_ZERO;
            smw_q      <= RST_ZERO;
            siw_q      <= RST_ZERO;
        end else begin
            aw_hold_q  <= aw_hold_d;
            w_hold_q   <= w_hold_d;
            awa_q      <= awa_d;
            wd_q       <= wd_d;
            ws_q       <= ws_d;
            bv_q       <= bv_d;
            br_q       <= br_d;
            rel_q      <= rel_d;
            rel_prev_q <= rel_q;
            priv_q     <= priv_d;
            ccd_q      <= ccd_d;
            mask_q     <= mask_d;
            lim_q      <= lim_d;
            xl_q       <= xl_d;
            pmw_q      <= pmw_d;
            piw_q      <= piw_d;
            smw_q      <= smw_d;
            siw_q      <= siw_d;
        end
    end

    // Read channel: one cycle from address to data
    always_comb begin
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end else if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = AXI_OKAY;
            case (s_axi_araddr[7:0])
                OFF_CTRL:        rd_d = {30'h0, priv_q, rel_q};
                OFF_STATUS:      rd_d = {27'h0, (st_q == PCMI_RUN), ccd_q, 1'b0, mode_q};
                OFF_BRIDGE_CTRL: rd_d = {31'h0, ccd_q};
                OFF_IDSEL_MASK:  rd_d = mask_q;
                OFF_IN_LIMIT:    rd_d = lim_q;
                OFF_IN_XLATE:    rd_d = xl_q;
                OFF_P_MEM_WIN:   rd_d = pmw_q;
                OFF_P_IO_WIN:    rd_d = piw_q;
                OFF_S_MEM_WIN:   rd_d = smw_q;
                OFF_S_IO_WIN:    rd_d = siw_q;
                OFF_FUNC_INFO:   rd_d = {28'h0, FUNC_XLATE, FUNC_BRIDGE};
                default: begin
                    rd_d = RST_ZERO;
                    rr_d = AXI_SLVERR;
                end
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rv_q <= 1'b0;
            rd_q <= RST_ZERO;
            rr_q <= AXI_OKAY;
        end else begin
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
        end
    end

    // Host-facing datapath, registered so every output comes from a flop
    logic        retry_d, accept_d, hit_d;
    logic [31:0] mask_ext;
    always_comb begin
        mask_ext = RST_ZERO;
        mask_ext[IDSEL_LO +: IDSEL_W] = mask_q[IDSEL_LO +: IDSEL_W];
        // Retry while the disable bit stands or the straps ask and the core is not done
        // Mode 3 also retries until the core runs, so the host never meets a half-set device
        retry_d  = cfg_req && (ccd_q || (mode_q == 2'h1) || st_q == PCMI_SAMPLE
                               || (mode_q == 2'h3 && st_q != PCMI_RUN));
        accept_d = cfg_req && !retry_d;
        hit_d    = ((host_addr & ~lim_q) == 32'h0000_0000);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_reset_n    <= 1'b0;
            boot_fetch_addr <= BOOT_ADDR;
            cfg_retry       <= 1'b0;
            cfg_accept      <= 1'b0;
            cfg_func_bridge <= 1'b0;
            cfg_func_xlate  <= 1'b0;
            in_hit          <= 1'b0;
            local_addr      <= RST_ZERO;
            sec_addr_out    <= RST_ZERO;
            sec_addr_oe     <= RST_ZERO;
            sec_fwd_grant   <= 1'b0;
            init_mode       <= 2'h3;
        end else begin
            core_reset_n    <= (st_d == PCMI_RUN);
            boot_fetch_addr <= BOOT_ADDR;
            cfg_retry       <= retry_d;
            cfg_accept      <= accept_d;
            cfg_func_bridge <= accept_d && (cfg_func == FUNC_BRIDGE);
            cfg_func_xlate  <= accept_d && (cfg_func == FUNC_XLATE);
            in_hit          <= hit_d;
            local_addr      <= xl_q | (host_addr & lim_q);
            sec_addr_out    <= sec_cfg_addr & ~mask_ext;
            sec_addr_oe     <= ~mask_ext;
            sec_fwd_grant   <= sec_fwd_req && !priv_q;
            init_mode       <= mode_q;
        end
    end

    assign s_axi_awready = !aw_hold_q && !bv_q;
    assign s_axi_wready  = !w_hold_q && !bv_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;

    // Checks
    sequence rel_rise_s;
        rel_q && !rel_prev_q;
    endsequence
    mode3_sets_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rel_rise_s and (mode_q == 2'h3) |=> ccd_q) else $error("disable bit not set");
    retry_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg_req && ccd_q) |=> cfg_retry && !cfg_accept) else $error("no retry");
    accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg_req && !ccd_q && mode_q != 2'h1 && st_q != PCMI_SAMPLE
         && !(mode_q == 2'h3 && st_q != PCMI_RUN)) |=> cfg_accept)
        else $error("access not accepted");
    hold_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == PCMI_HOLD && !mode_q[1]) |=> !core_reset_n) else $error("core released");
    boot_a: assert property (@(posedge aclk) disable iff (!aresetn)
        boot_fetch_addr == BOOT_ADDR) else $error("boot address wrong");
    func_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(cfg_func_bridge && cfg_func_xlate)) else $error("two functions hit");
    idsel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ((sec_addr_out & ~sec_addr_oe) == 32'h0)) else $error("masked bit driven");
    private_a: assert property (@(posedge aclk) disable iff (!aresetn)
        priv_q && $stable(priv_q) |=> !sec_fwd_grant) else $error("private forward");
    win_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (pmw_q == 32'h0 && smw_q == 32'h0)) else $error("window not zero");
endmodule
`default_nettype wire

// ---- pcmi_host_model.sv ----
// Primary bus host model that issues config accesses and reads back the answer
`timescale 1ns/1ps
`default_nettype none
module pcmi_host_model (
    input  wire logic       aclk,       // Clock
    input  wire logic       cfg_retry,  // Retry answer from the device
    input  wire logic       cfg_accept, // Accept answer from the device
    output logic            cfg_req,    // Config access request
    output logic [1:0]      cfg_func    // Function number addressed
);
    logic bases_set; // Host has assigned bases

    initial begin
        cfg_req   = 1'b0;
        cfg_func  = 2'h0;
        bases_set = 1'b0;
    end

    // One access: request held one cycle, answer read once it has landed
    task automatic access(input logic [1:0] f, output logic [1:0] ans);
        @(posedge aclk);
        cfg_req  <= 1'b1;
        cfg_func <= f;
        @(posedge aclk);
        cfg_req  <= 1'b0;
        cfg_func <= ~f; // Stale number would hide decode faults
        #1;
        ans = {cfg_retry, cfg_accept};
        // Bases go in only once the device lets the host in
        if (cfg_accept === 1'b1) begin
            bases_set = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// ---- pci_config_mode_init_control_tb.sv ----
// Self-checking bench for the start-up controller over its AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module pci_config_mode_init_control_tb;
    import pcmi_pkg::*;
    logic        aclk, aresetn, mode_strap, retry_strap, cfg_req, sec_fwd_req;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        core_reset_n, cfg_retry, cfg_accept, cfg_func_bridge, cfg_func_xlate;
    logic        in_hit, sec_fwd_grant;
    logic [1:0]  cfg_func, s_axi_bresp, s_axi_rresp, init_mode, r, ans;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] host_addr, sec_cfg_addr, s_axi_awaddr, s_axi_wdata, s_axi_araddr, d;
    logic [31:0] s_axi_rdata, boot_fetch_addr, local_addr, sec_addr_out, sec_addr_oe;
    logic [7:0]  win_off [4];
    int          failures, check_count, cyc;

    pcmi_top u_pcmi_top (.aclk, .aresetn, .mode_strap, .retry_strap, .cfg_req, .cfg_func,
        .host_addr, .sec_cfg_addr, .sec_fwd_req, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .core_reset_n, .boot_fetch_addr, .cfg_retry, .cfg_accept, .cfg_func_bridge,
        .cfg_func_xlate, .in_hit, .local_addr, .sec_addr_out, .sec_addr_oe,
        .sec_fwd_grant, .init_mode);

    pcmi_host_model u_pcmi_host_model (.aclk, .cfg_retry, .cfg_accept, .cfg_req, .cfg_func);

    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Hang guard, far above the expected run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= {24'h00, a};
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr  <= {24'h00, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Reset with straps set; straps need the sync and sample delay
    task automatic rst(input logic m, input logic t);
        @(posedge aclk);
        aresetn     <= 1'b0;
        mode_strap  <= m;
        retry_strap <= t;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        #1;
    endtask

    // Registered side outputs: one edge to sample, one to spare
    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask

    task end_of_test;
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, sec_fwd_req} = 3'h0;
        {mode_strap, retry_strap} = 2'h3;
        {host_addr, sec_cfg_addr} = 64'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hF;
        win_off = '{OFF_P_MEM_WIN, OFF_P_IO_WIN, OFF_S_MEM_WIN, OFF_S_IO_WIN};
        failures = 0;
        check_count = 0;
        // Every strap pattern, then core release and host access
        for (int m = 0; m < 4; m++) begin
            rst(m[1], m[0]);
            chk("init_mode", m, init_mode);
            u_pcmi_host_model.access(FUNC_BRIDGE, ans);
            chk("cfg_before_release", {m[0], !m[0]}, ans);
            axi_wr(OFF_CTRL, 32'h1, r);
            settle();
            chk("core_reset_n", m >= 2, core_reset_n);
            chk("boot_fetch_addr", BOOT_ADDR, boot_fetch_addr);
            repeat (2) begin
                u_pcmi_host_model.access(FUNC_BRIDGE, ans);
                chk("cfg_answer", {m[0], !m[0]}, ans);
            end
            axi_rd(OFF_STATUS, d, r);
            chk("cfg_disable", m == 3, d[3]);
        end
        // Core clears the disable bit; host is then let in
        axi_wr(OFF_BRIDGE_CTRL, 32'h0, r);
        u_pcmi_host_model.access(FUNC_BRIDGE, ans);
        chk("cfg_after_clear", 2'b01, ans);
        chk("bases_set", 1'b1, u_pcmi_host_model.bases_set);
        for (int f = 0; f < 2; f++) begin
            u_pcmi_host_model.access(f[1:0], ans);
            chk("func_bridge", f == 0, cfg_func_bridge);
            chk("func_xlate", f == 1, cfg_func_xlate);
        end
        foreach (win_off[i]) begin
            axi_rd(win_off[i], d, r);
            chk("window_reset", 32'h0, d);
            chk("window_resp", AXI_OKAY, r);
        end
        // Inbound window: inside and just outside the limit
        axi_wr(OFF_IN_LIMIT, 32'h0000_0FFF, r);
        axi_wr(OFF_IN_XLATE, 32'h1000_0000, r);
        @(posedge aclk);
        host_addr <= 32'h0000_0123;
        settle();
        chk("in_hit", 1'b1, in_hit);
        chk("local_addr", 32'h1000_0123, local_addr);
        @(posedge aclk);
        host_addr <= 32'h0000_1123;
        settle();
        chk("in_miss", 1'b0, in_hit);
        // Masked select bits are not driven, the rest are
        axi_wr(OFF_IDSEL_MASK, 32'h001F_0000, r);
        @(posedge aclk);
        sec_cfg_addr <= 32'h001F_0800;
        settle();
        chk("idsel_oe", 5'h00, sec_addr_oe[20:16]);
        chk("other_oe", 1'b1, sec_addr_oe[11]);
        chk("idsel_out", 32'h0000_0800, sec_addr_out);
        axi_wr(OFF_IDSEL_MASK, 32'h0, r);
        settle();
        chk("idsel_oe_open", 5'h1F, sec_addr_oe[20:16]);
        // Private secondary bus blocks forwarding
        @(posedge aclk);
        sec_fwd_req <= 1'b1;
        axi_wr(OFF_CTRL, 32'h3, r);
        settle();
        chk("fwd_private", 1'b0, sec_fwd_grant);
        axi_wr(OFF_CTRL, 32'h1, r);
        settle();
        chk("fwd_public", 1'b1, sec_fwd_grant);
        // Refused accesses, then a function info read that is accepted
        axi_rd(8'h40, d, r);
        chk("unmapped_resp", AXI_SLVERR, r);
        axi_wr(OFF_FUNC_INFO, 32'h0, r);
        chk("ro_write_resp", AXI_SLVERR, r);
        axi_rd(OFF_FUNC_INFO, d, r);
        chk("func_info", 32'h4, d);
        end_of_test();
    end
endmodule
`default_nettype wire
